/* File: core/vsg_params.svh */
`ifndef VSG_PARAMS_SVH
`define VSG_PARAMS_SVH

// ---------------------------------------------
// Register indices
// ---------------------------------------------
`define VSG_NREG        19
`define VSG_R_STATUS    8'h00
`define VSG_R_HFP       8'h01
`define VSG_R_HSE       8'h02
`define VSG_R_HBW       8'h03
`define VSG_R_HMAX      8'h04
`define VSG_R_VFP       8'h05
`define VSG_R_VSE       8'h06
`define VSG_R_VBW       8'h07
`define VSG_R_VMAX      8'h08
`define VSG_R_EQE       8'h09
`define VSG_R_SRE       8'h0a
`define VSG_R_ESS       8'h0b
`define VSG_R_ESE       8'h0c
`define VSG_R_VIS       8'h0d
`define VSG_R_VIE       8'h0e
`define VSG_R_HCS       8'h0f
`define VSG_R_HCE       8'h10
`define VSG_R_VCS       8'h11
`define VSG_R_VCE       8'h12

// ---------------------------------------------
// Status fields
// ---------------------------------------------
`define VSG_ST_SEL0     0
`define VSG_ST_SEL1     1
`define VSG_ST_SEL2     2
`define VSG_ST_MODE_LO  3
`define VSG_ST_MODE_HI  4
`define VSG_ST_POL_VCB  5
`define VSG_ST_POL_VCS  6
`define VSG_ST_POL_HBH  7
`define VSG_ST_POL_HSV  8
`define VSG_ST_EQ_OFF   9
`define VSG_ST_CLK_EN   10
`define VSG_ST_TEST     11
`define VSG_MODE_INTL   2'h0

// ---------------------------------------------
// Built-in defaults
// ---------------------------------------------
`define VSG_DEF_00      12'h403
`define VSG_DEF_01      12'h011
`define VSG_DEF_02      12'h052
`define VSG_DEF_03      12'h0a0
`define VSG_DEF_04      12'h38c
`define VSG_DEF_05      12'h007
`define VSG_DEF_06      12'h00d
`define VSG_DEF_07      12'h029
`define VSG_DEF_08      12'h20d
`define VSG_DEF_09      12'h02a
`define VSG_DEF_10      12'h1a4
`define VSG_DEF_11      12'h001
`define VSG_DEF_12      12'h013
`define VSG_DEF_13      12'h001
`define VSG_DEF_14      12'h004
`define VSG_DEF_15      12'h0b0
`define VSG_DEF_16      12'h300
`define VSG_DEF_17      12'h030
`define VSG_DEF_18      12'h200

`endif

/* File: core/vsg_pkg.sv */
package vsg_pkg;

   typedef logic [11:0] vsg_word_t;

   typedef enum logic {
      VSG_LD_IDLE,
      VSG_LD_HELD
   } vsg_ld_state_t;

endpackage : vsg_pkg

/* File: core/vsg_window.sv */
`timescale 1ns/100ps
module vsg_window
(
   input  wire logic [11:0] cnt,
   input  wire logic [11:0] start,
   input  wire logic [11:0] stop,
   output logic             active
);

   // Active from start up to, not including, stop
   always_comb
   begin
      active = (cnt >= start) && (cnt < stop);
   end

endmodule : vsg_window

/* File: core/vsg_regmem.sv */
`timescale 1ns/100ps
`include "vsg_params.svh"
module vsg_regmem
(
   input  wire logic                                   clk_sys,
   input  wire logic                                   rstn,
   input  wire logic                                   async_init_in,
   input  wire logic                                   wr_en,
   input  wire logic [7:0]                             wr_idx,
   input  wire logic                                   wr_hi,
   input  wire logic [7:0]                             wr_byte,
   output vsg_pkg::vsg_word_t [`VSG_NREG-1:0]          regs_q
);

   function automatic vsg_pkg::vsg_word_t def_val(input int k);
      case (k)
         0:       def_val = `VSG_DEF_00;
         1:       def_val = `VSG_DEF_01;
         2:       def_val = `VSG_DEF_02;
         3:       def_val = `VSG_DEF_03;
         4:       def_val = `VSG_DEF_04;
         5:       def_val = `VSG_DEF_05;
         6:       def_val = `VSG_DEF_06;
         7:       def_val = `VSG_DEF_07;
         8:       def_val = `VSG_DEF_08;
         9:       def_val = `VSG_DEF_09;
         10:      def_val = `VSG_DEF_10;
         11:      def_val = `VSG_DEF_11;
         12:      def_val = `VSG_DEF_12;
         13:      def_val = `VSG_DEF_13;
         14:      def_val = `VSG_DEF_14;
         15:      def_val = `VSG_DEF_15;
         16:      def_val = `VSG_DEF_16;
         17:      def_val = `VSG_DEF_17;
         default: def_val = `VSG_DEF_18;
      endcase
   endfunction : def_val

   genvar k;
   generate
      for (k = 0; k < `VSG_NREG; k++)
      begin : g_reg
         vsg_pkg::vsg_word_t reg_d;
         always_comb
         begin
            reg_d = regs_q[k];
            if (wr_en && (wr_idx == 8'(k)))
            begin
               if (wr_hi)
                  reg_d[11:8] = wr_byte[3:0];
               else
                  reg_d[7:0] = wr_byte;
            end
         end
         always_ff @(posedge clk_sys or negedge rstn or posedge async_init_in)
         begin
            if (!rstn || async_init_in)
               regs_q[k] <= def_val(k);
            else
               regs_q[k] <= reg_d;
         end
      end
   endgenerate

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   low_byte_a: assert property (@(posedge clk_sys) disable iff (!rstn || async_init_in)
      (wr_en && !wr_hi && wr_idx < 8'h13 && !async_init_in) |=>
      regs_q[$past(wr_idx)][7:0] == $past(wr_byte))
      else $error("low byte not stored");
   high_nib_a: assert property (@(posedge clk_sys) disable iff (!rstn || async_init_in)
      (wr_en && wr_hi && wr_idx < 8'h13 && !async_init_in) |=>
      regs_q[$past(wr_idx)][11:8] == $past(wr_byte[3:0]) &&
      regs_q[$past(wr_idx)][7:0] == $past(regs_q[wr_idx][7:0]))
      else $error("high nibble not stored");
   init_def_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      async_init_in |-> regs_q[0] == `VSG_DEF_00 && regs_q[4] == `VSG_DEF_04)
      else $error("clear did not restore defaults");

endmodule : vsg_regmem

/* File: core/vsg_gen.sv */
`timescale 1ns/100ps
`include "vsg_params.svh"
// Notes on behaviour
// - Separate H/V sync and blank, plus composite sync and blank outputs.
// - Interlaced or noninterlaced timing, chosen by status mode bits.
// - Equalization and serration pulses enter composite sync when enabled.
// - Composite selection frees outputs for four extra signal options.
// - Extras: horizontal gate, vertical gate, cursor, vertical interrupt.
// - Line and frame rates come only from registers and input clock.
// - Every pulse width comes from programmed end values; starts are programmed too, except blanking, which always starts at count 1.
// - Registers hold built-in broadcast defaults until host overwrites them.
// - Eight data inputs feed address register and data registers.
// - Qualifier captured on load strobe falling edge.
// - Qualifier 0 means address byte, 1 means data byte.
// - Half select captured on falling edge; 0 low eight, 1 high four.
// - Byte written on load strobe rising edge.
// - Clear high resets registers to defaults and counters asynchronously.
// - Data registers are twelve bits, filled by two loads.
module vsg_gen
(
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       async_init_in,
   input  wire logic [7:0] host_byte_in,
   input  wire logic       addr_data_sel,
   input  wire logic       half_word_select,
   input  wire logic       load_strobe,
   output logic            vc_sync_out,
   output logic            vc_blank_out,
   output logic            hblank_hdr_out,
   output logic            hsync_vdr_out,
   output logic            odd_even_out
);

   // ---------------------------------------------
   // Load port
   // ---------------------------------------------
   vsg_pkg::vsg_ld_state_t ld_state_q, ld_state_d;
   logic                   strobe_prev_q;
   logic                   sel_q, sel_d;
   logic                   half_q, half_d;
   logic [7:0]             addr_q, addr_d;
   logic                   wr_en;
   logic                   ld_fall;
   logic                   ld_rise;

   assign ld_fall = strobe_prev_q && !load_strobe;
   assign ld_rise = !strobe_prev_q && load_strobe;

   always_comb
   begin
      ld_state_d = ld_state_q;
      sel_d      = sel_q;
      half_d     = half_q;
      addr_d     = addr_q;
      wr_en      = 1'b0;
      case (ld_state_q)
         vsg_pkg::VSG_LD_IDLE:
         begin
            if (ld_fall)
            begin
               sel_d      = addr_data_sel;
               half_d     = half_word_select;
               ld_state_d = vsg_pkg::VSG_LD_HELD;
            end
         end
         default:
         begin
            if (ld_rise)
            begin
               ld_state_d = vsg_pkg::VSG_LD_IDLE;
               if (!sel_q)
                  addr_d = host_byte_in;
               else
                  wr_en = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn or posedge async_init_in)
   begin
      if (!rstn || async_init_in)
      begin
         ld_state_q    <= vsg_pkg::VSG_LD_IDLE;
         strobe_prev_q <= 1'b0;
         sel_q         <= 1'b0;
         half_q        <= 1'b0;
         addr_q        <= 8'h00;
      end
      else
      begin
         ld_state_q    <= ld_state_d;
         strobe_prev_q <= load_strobe;
         sel_q         <= sel_d;
         half_q        <= half_d;
         addr_q        <= addr_d;
      end
   end

   // ---------------------------------------------
   // Register store
   // ---------------------------------------------
   vsg_pkg::vsg_word_t [`VSG_NREG-1:0] regs;
   vsg_pkg::vsg_word_t                 st;

   vsg_regmem u_regmem
   (
      .clk_sys       (clk_sys),
      .rstn          (rstn),
      .async_init_in (async_init_in),
      .wr_en         (wr_en),
      .wr_idx        (addr_q),
      .wr_hi         (half_q),
      .wr_byte       (host_byte_in),
      .regs_q        (regs)
   );

   assign st = regs[`VSG_R_STATUS];

   // ---------------------------------------------
   // Mode decode
   // ---------------------------------------------
   logic [1:0] mode;
   logic       intl;
   logic       dbl;
   logic       run;
   logic       eqs_on;

   assign mode   = st[`VSG_ST_MODE_HI:`VSG_ST_MODE_LO];
   assign intl   = (mode == `VSG_MODE_INTL);
   assign dbl    = !st[`VSG_ST_MODE_HI]; // Illegal mode runs as single
   assign run    = st[`VSG_ST_CLK_EN];
   assign eqs_on = !st[`VSG_ST_EQ_OFF];

   // ---------------------------------------------
   // Line and frame counters
   // ---------------------------------------------
   vsg_pkg::vsg_word_t hcnt_q, hcnt_d;
   vsg_pkg::vsg_word_t vcnt_q, vcnt_d;
   logic               field_q, field_d;
   vsg_pkg::vsg_word_t hmax;
   vsg_pkg::vsg_word_t vmax;
   vsg_pkg::vsg_word_t half;
   logic               h_wrap;
   logic               v_step;

   assign hmax   = regs[`VSG_R_HMAX];
   assign vmax   = regs[`VSG_R_VMAX];
   assign half   = {1'b0, hmax[11:1]};
   assign h_wrap = (hcnt_q >= hmax);
   // Interlace steps the vertical count every half line
   assign v_step = h_wrap || (intl && (hcnt_q == half));

   always_comb
   begin
      hcnt_d  = hcnt_q;
      vcnt_d  = vcnt_q;
      field_d = field_q;
      if (run)
      begin
         hcnt_d = h_wrap ? 12'h001 : hcnt_q + 12'h001;
         if (v_step)
         begin
            if (vcnt_q >= vmax)
            begin
               vcnt_d  = 12'h001;
               field_d = intl ? !field_q : 1'b1;
            end
            else
               vcnt_d = vcnt_q + 12'h001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn or posedge async_init_in)
   begin
      if (!rstn || async_init_in)
      begin
         hcnt_q  <= 12'h001;
         vcnt_q  <= 12'h001;
         field_q <= 1'b1;
      end
      else
      begin
         hcnt_q  <= hcnt_d;
         vcnt_q  <= vcnt_d;
         field_q <= field_d;
      end
   end

   // ---------------------------------------------
   // Pulse windows
   // ---------------------------------------------
   localparam int NWIN = 10;
   localparam int W_HS = 0;
   localparam int W_HB = 1;
   localparam int W_VS = 2;
   localparam int W_VB = 3;
   localparam int W_EI = 4;
   localparam int W_VI = 5;
   localparam int W_HG = 6;
   localparam int W_VG = 7;
   localparam int W_EQ = 8;
   localparam int W_SR = 9;

   vsg_pkg::vsg_word_t hp;
   vsg_pkg::vsg_word_t w_cnt   [NWIN];
   vsg_pkg::vsg_word_t w_start [NWIN];
   vsg_pkg::vsg_word_t w_stop  [NWIN];
   logic [NWIN-1:0]    win;

   // Position within the half line for double rate pulses
   assign hp = (dbl && hcnt_q > half) ? hcnt_q - half : hcnt_q;

   always_comb
   begin
      w_cnt[W_HS]   = hcnt_q;
      w_start[W_HS] = regs[`VSG_R_HFP];
      w_stop[W_HS]  = regs[`VSG_R_HSE];
      w_cnt[W_HB]   = hcnt_q;
      w_start[W_HB] = 12'h001;
      w_stop[W_HB]  = regs[`VSG_R_HBW];
      w_cnt[W_VS]   = vcnt_q;
      w_start[W_VS] = regs[`VSG_R_VFP];
      w_stop[W_VS]  = regs[`VSG_R_VSE];
      w_cnt[W_VB]   = vcnt_q;
      w_start[W_VB] = 12'h001;
      w_stop[W_VB]  = regs[`VSG_R_VBW];
      w_cnt[W_EI]   = vcnt_q;
      w_start[W_EI] = regs[`VSG_R_ESS];
      w_stop[W_EI]  = regs[`VSG_R_ESE];
      w_cnt[W_VI]   = vcnt_q;
      w_start[W_VI] = regs[`VSG_R_VIS];
      w_stop[W_VI]  = regs[`VSG_R_VIE];
      w_cnt[W_HG]   = hcnt_q;
      w_start[W_HG] = regs[`VSG_R_HCS];
      w_stop[W_HG]  = regs[`VSG_R_HCE];
      w_cnt[W_VG]   = vcnt_q;
      w_start[W_VG] = regs[`VSG_R_VCS];
      w_stop[W_VG]  = regs[`VSG_R_VCE];
      w_cnt[W_EQ]   = hp;
      w_start[W_EQ] = regs[`VSG_R_HFP];
      w_stop[W_EQ]  = regs[`VSG_R_EQE];
      w_cnt[W_SR]   = hp;
      w_start[W_SR] = regs[`VSG_R_HFP];
      w_stop[W_SR]  = regs[`VSG_R_SRE];
   end

   genvar g;
   generate
      for (g = 0; g < NWIN; g++)
      begin : g_win
         vsg_window u_win
         (
            .cnt    (w_cnt[g]),
            .start  (w_start[g]),
            .stop   (w_stop[g]),
            .active (win[g])
         );
      end
   endgenerate

   // ---------------------------------------------
   // Signal composition
   // ---------------------------------------------
   logic csync;
   logic cblank;
   logic cursor;
   logic eq_zone;
   logic vcb_sel;
   logic vcs_sel;
   logic hbh_sel;
   logic hsv_sel;

   assign eq_zone = win[W_EI] && !win[W_VS];
   assign cblank  = win[W_HB] || win[W_VB];
   assign cursor  = win[W_HG] && win[W_VG];

   always_comb
   begin
      if (!eqs_on)
         csync = win[W_HS] || win[W_VS];
      else if (win[W_VS])
         csync = win[W_SR];
      else if (eq_zone)
         csync = win[W_EQ];
      else
         csync = win[W_HS];
   end

   always_comb
   begin
      vcb_sel = st[`VSG_ST_SEL0] ? win[W_VB] : cblank;
      vcs_sel = st[`VSG_ST_SEL1] ? win[W_VS] : csync;
      if (st[`VSG_ST_SEL0])
         hbh_sel = win[W_HB];
      else
         hbh_sel = st[`VSG_ST_SEL2] ? cursor : win[W_HG];
      if (st[`VSG_ST_SEL1])
         hsv_sel = win[W_HS];
      else
         hsv_sel = st[`VSG_ST_SEL2] ? win[W_VI] : win[W_VG];
   end

   // ---------------------------------------------
   // Output registers
   // ---------------------------------------------
   logic vcs_d, vcb_d, hbh_d, hsv_d, oe_d;

   always_comb
   begin
      // Polarity bit 0 drives active low
      vcb_d = !(vcb_sel ^ st[`VSG_ST_POL_VCB]);
      vcs_d = !(vcs_sel ^ st[`VSG_ST_POL_VCS]);
      hbh_d = !(hbh_sel ^ st[`VSG_ST_POL_HBH]);
      hsv_d = !(hsv_sel ^ st[`VSG_ST_POL_HSV]);
      oe_d  = intl ? field_q : 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rstn or posedge async_init_in)
   begin
      if (!rstn || async_init_in)
      begin
         vc_sync_out    <= 1'b1;
         vc_blank_out   <= 1'b1;
         hblank_hdr_out <= 1'b1;
         hsync_vdr_out  <= 1'b1;
         odd_even_out   <= 1'b1;
      end
      else
      begin
         vc_sync_out    <= vcs_d;
         vc_blank_out   <= vcb_d;
         hblank_hdr_out <= hbh_d;
         hsync_vdr_out  <= hsv_d;
         odd_even_out   <= oe_d;
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn || async_init_in);

   sequence s_fall;
      ld_state_q == vsg_pkg::VSG_LD_IDLE && strobe_prev_q && !load_strobe;
   endsequence
   sequence s_rise;
      ld_state_q == vsg_pkg::VSG_LD_HELD && !strobe_prev_q && load_strobe;
   endsequence

   qual_capture_a: assert property (s_fall |=> sel_q == $past(addr_data_sel)
      && half_q == $past(half_word_select))
      else $error("qualifiers not captured on fall");
   addr_load_a: assert property ((s_rise and !sel_q) |=>
      addr_q == $past(host_byte_in) && !$past(wr_en))
      else $error("address byte not loaded");
   data_write_a: assert property ((s_rise and sel_q) |-> wr_en
      ##1 $stable(addr_q))
      else $error("data byte not written");
   line_wrap_a: assert property ((run && hcnt_q >= hmax) |=> hcnt_q == 12'h001)
      else $error("line counter did not wrap");
   clk_hold_a: assert property (!run |=> $stable(hcnt_q) && $stable(vcnt_q))
      else $error("counters moved while stopped");
   odd_even_a: assert property (!intl |=> odd_even_out)
      else $error("odd/even low outside interlace");
   sep_hsync_a: assert property ((st[1] && st[8]) ##1 $stable(st) |->
      hsync_vdr_out == $past(win[W_HS]))
      else $error("horizontal sync output wrong");
   comp_plain_a: assert property ((!eqs_on && !st[1] && st[6]) ##1 $stable(st) |->
      vc_sync_out == $past(win[W_HS] || win[W_VS]))
      else $error("composite sync wrong");

endmodule : vsg_gen

/* File: tb/vsg_host_model.sv */
`timescale 1ns/100ps
module vsg_host_model
(
   input  wire logic       clk_sys,
   output logic            load_strobe,
   output logic            addr_data_sel,
   output logic            half_word_select,
   output logic [7:0]      host_byte_in
);
   initial
   begin
      load_strobe      = 1'b1;
      addr_data_sel    = 1'b0;
      half_word_select = 1'b0;
      host_byte_in     = 8'h00;
   end

   // ---------------------------------
   // Byte loads
   // ---------------------------------
   task automatic put(input logic sel, input logic half, input logic [7:0] val, input int gap);
      @(negedge clk_sys);
      load_strobe      = 1'b0;
      addr_data_sel    = sel;
      half_word_select = half;
      for (int i = 0; i < gap; i++)
      begin
         @(negedge clk_sys);
         host_byte_in = ~host_byte_in;
      end
      @(negedge clk_sys);
      host_byte_in = val;
      load_strobe  = 1'b1;
      @(negedge clk_sys);
      host_byte_in     = ~val;
      addr_data_sel    = ~sel;
      half_word_select = ~half;
   endtask : put

   // Address once, then both halves of the word
   task automatic wr(input logic [7:0] idx, input logic [11:0] word, input logic hi_first, input int gap);
      put(1'b0, 1'b0, idx, gap);
      if (hi_first)
      begin
         put(1'b1, 1'b1, {4'h0, word[11:8]}, gap);
         put(1'b1, 1'b0, word[7:0], gap);
      end
      else
      begin
         put(1'b1, 1'b0, word[7:0], gap);
         put(1'b1, 1'b1, {4'h0, word[11:8]}, gap);
      end
   endtask : wr

   task automatic drop();
      @(negedge clk_sys);
      load_strobe = 1'b0;
   endtask : drop

   task automatic rise_only(input logic [7:0] val);
      @(negedge clk_sys);
      host_byte_in = val;
      load_strobe  = 1'b1;
      @(negedge clk_sys);
      host_byte_in = ~val;
   endtask : rise_only
endmodule : vsg_host_model

/* File: tb/video_sync_gen_load_port_test.sv */
`timescale 1ns/100ps
module video_sync_gen_load_port_test;
   logic        clk_sys;
   logic        rstn;
   logic        async_init_in;
   logic        load_strobe;
   logic        addr_data_sel;
   logic        half_word_select;
   logic [7:0]  host_byte_in;
   logic        vc_sync_out;
   logic        vc_blank_out;
   logic        hblank_hdr_out;
   logic        hsync_vdr_out;
   logic        odd_even_out;
   logic [4:0]  outs;
   logic [4:0]  snap;
   logic [31:0] r;
   int          bad_count;
   int          n_compared;
   int          seed;
   int          h1, h2, h3, h4, w, p, n;

   assign outs = {odd_even_out, hsync_vdr_out, hblank_hdr_out, vc_blank_out, vc_sync_out};

   vsg_gen dut
   (
      .clk_sys          (clk_sys),
      .rstn             (rstn),
      .async_init_in    (async_init_in),
      .host_byte_in     (host_byte_in),
      .addr_data_sel    (addr_data_sel),
      .half_word_select (half_word_select),
      .load_strobe      (load_strobe),
      .vc_sync_out      (vc_sync_out),
      .vc_blank_out     (vc_blank_out),
      .hblank_hdr_out   (hblank_hdr_out),
      .hsync_vdr_out    (hsync_vdr_out),
      .odd_even_out     (odd_even_out)
   );

   vsg_host_model host
   (
      .clk_sys          (clk_sys),
      .load_strobe      (load_strobe),
      .addr_data_sel    (addr_data_sel),
      .half_word_select (half_word_select),
      .host_byte_in     (host_byte_in)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ---------------------------------
   // Expectations and checks
   // ---------------------------------
   function automatic int exp_sync_w(input int a1, input int a2);
      return a2 - a1;
   endfunction : exp_sync_w

   function automatic int exp_blank_w(input int a3);
      return a3 - 1;
   endfunction : exp_blank_w

   task automatic test_done();
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   task automatic cmp_int(input int got, input int exp);
      n_compared++;
      if (got != exp)
      begin
         bad_count++;
         $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : cmp_int

   task automatic cmp_bit(input logic [4:0] got, input logic [4:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t outputs %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit

   // Skips one pulse to resync, then active width and period
   task automatic measure(input int idx, input logic act, output int mw, output int mp);
      int k;
      for (k = 0; k < 4; k++)
      begin
         n = 0;
         while (outs[idx] !== (k[0] ? act : ~act) && n < 5000)
         begin
            @(negedge clk_sys);
            n++;
         end
      end
      mw = 0;
      while (outs[idx] === act && mw < 5000)
      begin
         @(negedge clk_sys);
         mw++;
      end
      mp = mw;
      while (outs[idx] !== act && mp < 9000)
      begin
         @(negedge clk_sys);
         mp++;
      end
   endtask : measure

   task automatic chk_line(input int a1, input int a2, input int a3, input int a4, input logic hs_act);
      measure(3, hs_act, w, p);
      cmp_int(w, exp_sync_w(a1, a2));
      cmp_int(p, a4);
      measure(2, 1'b0, w, p);
      cmp_int(w, exp_blank_w(a3));
      cmp_int(p, a4);
   endtask : chk_line

   initial
   begin
      #(80000 * 25);
      bad_count++;
      test_done();
   end

   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial
   begin
      seed          = 9;
      bad_count     = 0;
      n_compared    = 0;
      rstn          = 1'b0;
      async_init_in = 1'b0;
      @(negedge clk_sys);
      cmp_bit(outs, 5'h1f);
      @(negedge clk_sys);
      rstn = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_line(12'h011, 12'h052, 12'h0a0, 12'h38c, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         r  = $random(seed);
         h4 = 60 + 2 * int'(r[4:0]);
         h1 = 2 + int'(r[7:5]);
         h2 = h1 + 1 + int'(r[11:8]);
         h3 = h2 + 1 + int'(r[15:12]);
         host.wr(8'h04, 12'(h4), r[16], int'(r[18:17]));
         host.wr(8'h01, 12'(h1), r[19], int'(r[21:20]));
         host.wr(8'h02, 12'(h2), r[22], 0);
         host.wr(8'h03, 12'(h3), r[23], 1);
         chk_line(h1, h2, h3, h4, 1'b0);
      end
      host.wr(8'h13, 12'h005, 1'b0, 0);
      chk_line(h1, h2, h3, h4, 1'b0);
      host.wr(8'h00, 12'h503, 1'b0, 0);
      chk_line(h1, h2, h3, h4, 1'b1);
      host.wr(8'h0f, 12'h003, 1'b0, 0);
      host.wr(8'h10, 12'h008, 1'b1, 0);
      host.wr(8'h00, 12'h400, 1'b0, 0);
      measure(2, 1'b0, w, p);
      cmp_int(w, 5);
      cmp_int(p, h4);
      host.wr(8'h00, 12'h003, 1'b0, 0);
      repeat (3) @(negedge clk_sys);
      snap = outs;
      n    = 0;
      repeat (200)
      begin
         @(negedge clk_sys);
         if (outs !== snap)
            n++;
      end
      cmp_int(n, 0);
      host.wr(8'h04, 12'h014, 1'b0, 0);
      host.wr(8'h08, 12'h00b, 1'b1, 0);
      host.wr(8'h00, 12'h403, 1'b0, 0);
      measure(4, 1'b1, w, p);
      cmp_int(w, 110);
      cmp_int(p, 220);
      host.wr(8'h00, 12'h41b, 1'b0, 0);
      repeat (3) @(negedge clk_sys);
      n = 0;
      repeat (300)
      begin
         @(negedge clk_sys);
         if (odd_even_out !== 1'b1)
            n++;
      end
      cmp_int(n, 0);
      host.wr(8'h04, 12'h10c, 1'b1, 0);
      chk_line(h1, h2, h3, 268, 1'b0);
      // Empty vertical sync window, composite sync active high
      host.wr(8'h06, 12'h007, r[24], 0);
      host.wr(8'h00, 12'h640, 1'b0, 0);
      measure(0, 1'b1, w, p);
      cmp_int(w, exp_sync_w(h1, h2));
      cmp_int(p, 268);
      // Equalization on: pulses end at default 0x02a, twice per line
      host.wr(8'h00, 12'h440, 1'b0, 0);
      measure(0, 1'b1, w, p);
      cmp_int(w, exp_sync_w(h1, 12'h02a));
      cmp_int(p, 268 / 2);
      host.drop();
      @(negedge clk_sys);
      async_init_in = 1'b1;
      #1;
      cmp_bit(outs, 5'h1f);
      @(negedge clk_sys);
      async_init_in = 1'b0;
      host.rise_only(8'h0c);
      chk_line(12'h011, 12'h052, 12'h0a0, 12'h38c, 1'b0);
      test_done();
   end
endmodule : video_sync_gen_load_port_test
